//--- ptpcfg_detect.sv
// Purpose: per-port transmit message detection configuration and match
// Assumes: the transmit path hands over parsed destination fields
// Notes:   result stands one cycle after the descriptor strobe
//
// Functional notes
// - first layer-2 enable accepts 01:80:C2:00:00:0E as destination.
// - second layer-2 enable accepts 01:1B:19:00:00:00 as destination.
// - set one accepts IPv4 MAC ..01:81 and 224.0.1.129.
// - set one accepts IPv6 MAC 33:33..01:81 and FF0X::181.
// - set two accepts IPv4 MAC ..01:82 and 224.0.1.130.
// - set two accepts IPv6 MAC 33:33..01:82 and FF0X::182.
// - set three accepts IPv4 MAC ..01:83 and 224.0.1.131.
// - set three accepts IPv6 MAC 33:33..01:83 and FF0X::183.
// - set four accepts IPv4 MAC ..01:84 and 224.0.1.132.
// - set four accepts IPv6 MAC 33:33..01:84 and FF0X::184.
// - set five accepts IPv4 MAC ..00:6B and 224.0.0.107.
// - set five accepts IPv6 MAC 33:33..00:6B and FF02::6B.
// - bit 7 accepts the software layer-2 MAC for layer-2 frames.
// - bit 6 accepts the software MAC for IPv6 frames.
// - bit 5 accepts the software MAC for IPv4 frames.
// - bit 4 turns on IP destination checking, both IP versions.
// - bit 3 turns on destination MAC checking.
// - bit 2 enables detection of layer-2 encapsulated messages.
// - bit 1 enables detection of UDP over IPv6 messages.
// - bit 0 enables detection of UDP over IPv4 messages.
// - access goes through bank select and port select fields.
//
// Strobed register access and the register addresses were decided locally.
`default_nettype none

module ptpcfg_detect
#(
    parameter int PORTS = 3
)
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // register port
    input  wire logic [ptpcfg_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [ptpcfg_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [ptpcfg_pkg::DATA_W-1:0]      reg_rdata,
    // software defined address
    input  wire logic [15:0]           custom_mac_upper,
    input  wire logic [31:0]           custom_mac_lower,
    // frame descriptor from the transmit path
    input  wire logic                  frm_valid,
    input  wire logic [1:0]            frm_port,
    input  wire logic [3:0]            frm_kind,
    input  wire logic [47:0]           frm_dst_mac,
    input  wire logic [127:0]          frm_dst_ip,
    // detection result
    output logic                       det_valid,
    output logic                       det_ptp,
    output logic [1:0]                 det_port
);

    import ptpcfg_pkg::*;

    // the two-bit port select cannot reach more than four ports
    if (PORTS < 1 || PORTS > MAX_PORTS)
    begin : g_bad_ports
        $error("PORTS must lie between 1 and 4");
    end

    logic [BANK_SEL_W-1:0] bank_sel;
    logic [PORT_SEL_W-1:0] port_sel;
    logic [CFG_W-1:0]      cfg [PORTS];
    logic [CFG_W-1:0]      sel_cfg;
    logic                  sel_valid;
    logic                  cfg_hit;
    logic                  sel_hit;
    logic                  stat_hit;
    logic [1:0]            stat_port;
    logic [3:0]            stat_kind;
    logic [STAT_CNT_W-1:0] stat_cnt;
    logic [CFG_W-1:0]      fcfg;
    logic [47:0]           user_mac;
    logic [NUM_SETS-1:0]   set_en;
    logic                  l2_mac_ok;
    logic                  v4_mac_ok;
    logic                  v4_ip_ok;
    logic                  v6_mac_ok;
    logic                  v6_ip_ok;
    logic                  next_ptp;

    // address decode
    assign sel_hit   = (reg_addr == BANK_PORT_OFS);
    assign cfg_hit   = (reg_addr == PARSE_CFG_OFS)
                     && (bank_sel == PARSE_CFG_BANK);
    assign sel_valid = (int'(port_sel) < PORTS);

    always_comb
    begin
        sel_cfg = '0;
        for (int i = 0; i < PORTS; i++)
        begin
            if (int'(port_sel) == i)
            begin
                sel_cfg = cfg[i];
            end
        end
    end

    // bank select
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            bank_sel <= '0;
        end
        else if (reg_wr && sel_hit)
        begin
            bank_sel <= reg_wdata[BANK_SEL_LSB +: BANK_SEL_W];
        end
    end

    // port select; a port past PORTS is held but reaches no config
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            port_sel <= '0;
        end
        else if (reg_wr && sel_hit)
        begin
            port_sel <= reg_wdata[PORT_SEL_LSB +: PORT_SEL_W];
        end
    end

    // per-port configuration; upper bits are not stored at all
    // no hardware lock while timestamping runs; software holds it still
    generate
        for (genvar p = 0; p < PORTS; p++)
        begin : g_cfg
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    cfg[p] <= PARSE_CFG_RST;
                end
                else if (reg_wr && cfg_hit && int'(port_sel) == p)
                begin
                    cfg[p] <= reg_wdata[CFG_W-1:0];
                end
            end
        end
    endgenerate

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= '0;
        end
        else if (reg_rd)
        begin
            if (sel_hit)
            begin
                reg_rdata <= '0;
                reg_rdata[BANK_SEL_LSB +: BANK_SEL_W] <= bank_sel;
                reg_rdata[PORT_SEL_LSB +: PORT_SEL_W] <= port_sel;
            end
            else if (reg_addr == DET_STATUS_OFS)
            begin
                reg_rdata <= '0;
                reg_rdata[STAT_HIT_BIT]             <= stat_hit;
                reg_rdata[STAT_PORT_LSB +: 2]       <= stat_port;
                reg_rdata[STAT_KIND_LSB +: 4]       <= stat_kind;
                reg_rdata[STAT_CNT_W-1:0]           <= stat_cnt;
            end
            else if (cfg_hit && sel_valid)
            begin
                reg_rdata <= {{(DATA_W-CFG_W){1'b0}}, sel_cfg};
            end
            else
            begin
                reg_rdata <= '0;
            end
        end
        else
        begin
            reg_rdata <= '0;
        end
    end

    // configuration of the port that sends the frame
    always_comb
    begin
        fcfg = '0;
        for (int i = 0; i < PORTS; i++)
        begin
            if (int'(frm_port) == i)
            begin
                fcfg = cfg[i];
            end
        end
    end

    // software MAC is a level from outside, not stored here
    assign user_mac = {custom_mac_upper, custom_mac_lower};
    // index 0 is set one, so the field is reversed
    always_comb
    begin
        for (int s = 0; s < NUM_SETS; s++)
        begin
            set_en[s] = fcfg[SET_ONE_BIT - s];
        end
    end

    // layer-2 destinations
    always_comb
    begin
        l2_mac_ok = 1'b0;
        if (fcfg[L2_ONE_BIT] && frm_dst_mac == L2_MAC_ONE)
        begin
            l2_mac_ok = 1'b1;
        end
        if (fcfg[L2_TWO_BIT] && frm_dst_mac == L2_MAC_TWO)
        begin
            l2_mac_ok = 1'b1;
        end
        if (fcfg[CUST_L2_BIT] && frm_dst_mac == user_mac)
        begin
            l2_mac_ok = 1'b1;
        end
    end

    // IPv4 sets; mac and ip checked per enabled set
    always_comb
    begin
        v4_mac_ok = fcfg[CUST_V4_BIT] && frm_dst_mac == user_mac;
        v4_ip_ok  = 1'b0;
        for (int s = 0; s < NUM_SETS; s++)
        begin
            if (set_en[s] && frm_dst_mac == V4_MAC[s])
            begin
                v4_mac_ok = 1'b1;
            end
            if (set_en[s] && frm_dst_ip[31:0] == V4_IP[s])
            begin
                v4_ip_ok = 1'b1;
            end
        end
    end

    // IPv6 sets; scope nibble masked for sets one to four
    always_comb
    begin
        v6_mac_ok = fcfg[CUST_V6_BIT] && frm_dst_mac == user_mac;
        v6_ip_ok  = 1'b0;
        for (int s = 0; s < NUM_SETS; s++)
        begin
            if (set_en[s] && frm_dst_mac == V6_MAC[s])
            begin
                v6_mac_ok = 1'b1;
            end
            if (set_en[s] && (frm_dst_ip & V6_MASK[s]) == V6_IP[s])
            begin
                v6_ip_ok = 1'b1;
            end
        end
    end

    // final decision; an unchecked field always passes
    always_comb
    begin
        next_ptp = 1'b0;
        case (frm_kind)
            PTPCFG_L2:
            begin
                next_ptp = fcfg[L2_DET_BIT]
                    && (!fcfg[MAC_CHECK_BIT] || l2_mac_ok);
            end
            PTPCFG_V4:
            begin
                next_ptp = fcfg[V4_DET_BIT]
                    && (!fcfg[MAC_CHECK_BIT] || v4_mac_ok)
                    && (!fcfg[IP_CHECK_BIT] || v4_ip_ok);
            end
            PTPCFG_V6:
            begin
                next_ptp = fcfg[V6_DET_BIT]
                    && (!fcfg[MAC_CHECK_BIT] || v6_mac_ok)
                    && (!fcfg[IP_CHECK_BIT] || v6_ip_ok);
            end
            default:
            begin
                next_ptp = 1'b0;
            end
        endcase
        // a port beyond the instance count never matches
        if (int'(frm_port) >= PORTS)
        begin
            next_ptp = 1'b0;
        end
    end

    // result pulse, one cycle after the descriptor
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            det_valid <= 1'b0;
        end
        else
        begin
            det_valid <= frm_valid;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            det_ptp <= 1'b0;
        end
        else
        begin
            det_ptp <= frm_valid && next_ptp;
        end
    end

    // port holds between descriptors so the last one stays visible
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            det_port <= '0;
        end
        else if (frm_valid)
        begin
            det_port <= frm_port;
        end
    end

    // status of the last frame
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            stat_hit  <= 1'b0;
            stat_port <= '0;
            stat_kind <= '0;
        end
        else if (frm_valid)
        begin
            stat_hit  <= next_ptp;
            stat_port <= frm_port;
            stat_kind <= frm_kind;
        end
    end

    // hit count saturates rather than wrapping back to a small value
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            stat_cnt <= '0;
        end
        else if (frm_valid && next_ptp && stat_cnt != {STAT_CNT_W{1'b1}})
        begin
            stat_cnt <= stat_cnt + 1'b1;
        end
    end

endmodule

`default_nettype wire

//--- ptpcfg_pkg.sv
// Purpose: constants for the transmit message detection configuration
// Assumes: one register port, one clock domain
// Notes:   well-known destination addresses are held as constant tables
`default_nettype none

package ptpcfg_pkg;

    // register port geometry
    localparam int          ADDR_W         = 10;
    localparam int          DATA_W         = 32;
    localparam int          CFG_W          = 15;
    localparam int          MAX_PORTS      = 4;

    // register map
    localparam logic [9:0]  BANK_PORT_OFS  = 10'h000;
    localparam logic [9:0]  DET_STATUS_OFS = 10'h004;
    localparam logic [9:0]  PARSE_CFG_OFS  = 10'h158;
    localparam logic [2:0]  PARSE_CFG_BANK = 3'h2;

    // bank and port select fields
    localparam int          BANK_SEL_LSB   = 0;
    localparam int          BANK_SEL_W     = 3;
    localparam int          PORT_SEL_LSB   = 8;
    localparam int          PORT_SEL_W     = 2;

    // configuration field positions
    localparam int          L2_ONE_BIT     = 14;
    localparam int          L2_TWO_BIT     = 13;
    localparam int          SET_ONE_BIT    = 12;
    localparam int          SET_FIVE_BIT   = 8;
    localparam int          CUST_L2_BIT    = 7;
    localparam int          CUST_V6_BIT    = 6;
    localparam int          CUST_V4_BIT    = 5;
    localparam int          IP_CHECK_BIT   = 4;
    localparam int          MAC_CHECK_BIT  = 3;
    localparam int          L2_DET_BIT     = 2;
    localparam int          V6_DET_BIT     = 1;
    localparam int          V4_DET_BIT     = 0;
    localparam logic [14:0] PARSE_CFG_RST  = 15'h711f;

    // detection status fields
    localparam int          STAT_HIT_BIT   = 31;
    localparam int          STAT_PORT_LSB  = 24;
    localparam int          STAT_KIND_LSB  = 16;
    localparam int          STAT_CNT_W     = 16;

    // encapsulation of an outgoing frame, one-hot
    typedef enum logic [3:0]
    {
        PTPCFG_OTHER = 4'b0001,
        PTPCFG_L2    = 4'b0010,
        PTPCFG_V4    = 4'b0100,
        PTPCFG_V6    = 4'b1000
    } ptpcfg_kind_t;

    // fixed layer-2 addresses
    localparam logic [47:0] L2_MAC_ONE     = 48'h0180_c200_000e;
    localparam logic [47:0] L2_MAC_TWO     = 48'h011b_1900_0000;

    // address sets one to five, index 0 is set one
    localparam int          NUM_SETS       = 5;
    localparam logic [47:0] V4_MAC [NUM_SETS] = '{
        48'h0100_5e00_0181, 48'h0100_5e00_0182, 48'h0100_5e00_0183,
        48'h0100_5e00_0184, 48'h0100_5e00_006b};
    localparam logic [31:0] V4_IP [NUM_SETS] = '{
        32'he000_0181, 32'he000_0182, 32'he000_0183,
        32'he000_0184, 32'he000_006b};
    localparam logic [47:0] V6_MAC [NUM_SETS] = '{
        48'h3333_0000_0181, 48'h3333_0000_0182, 48'h3333_0000_0183,
        48'h3333_0000_0184, 48'h3333_0000_006b};
    localparam logic [127:0] V6_IP [NUM_SETS] = '{
        128'hff00_0000_0000_0000_0000_0000_0000_0181,
        128'hff00_0000_0000_0000_0000_0000_0000_0182,
        128'hff00_0000_0000_0000_0000_0000_0000_0183,
        128'hff00_0000_0000_0000_0000_0000_0000_0184,
        128'hff02_0000_0000_0000_0000_0000_0000_006b};
    // scope nibble is a wildcard for sets one to four
    localparam logic [127:0] V6_ANY_SCOPE  =
        128'hfff0_ffff_ffff_ffff_ffff_ffff_ffff_ffff;
    localparam logic [127:0] V6_EXACT      = {128{1'b1}};
    localparam logic [127:0] V6_MASK [NUM_SETS] = '{
        V6_ANY_SCOPE, V6_ANY_SCOPE, V6_ANY_SCOPE, V6_ANY_SCOPE, V6_EXACT};

endpackage

`default_nettype wire

//--- ptpcfg_detect_assertions.sv
// Purpose: port timing and refusal checks for the detector
// Assumes: one clock, reset disables every check
// Notes:   config contents are judged by the bench
`default_nettype none
module ptpcfg_detect_assertions
    import ptpcfg_pkg::*;
#(
    parameter int PORTS = 3
)
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // register port
    input wire logic [9:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // descriptor and result
    input wire logic        frm_valid,
    input wire logic [1:0]  frm_port,
    input wire logic [3:0]  frm_kind,
    input wire logic        det_valid,
    input wire logic        det_ptp,
    input wire logic [1:0]  det_port
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_pulse;
        frm_valid |=> det_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("no result");
    property p_quiet;
        !frm_valid |=> !det_valid && !det_ptp;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray result");
    property p_port;
        frm_valid |=> det_port == $past(frm_port);
    endproperty
    a_port: assert property (p_port) else $error("bad port");
    property p_hold;
        !frm_valid |=> $stable(det_port);
    endproperty
    a_hold: assert property (p_hold) else $error("port moved");
    property p_other;
        frm_valid && frm_kind == PTPCFG_OTHER |=> !det_ptp;
    endproperty
    a_other: assert property (p_other) else $error("other hit");
    // ports beyond the built count have no config, so never hit
    property p_noport;
        frm_valid && frm_port >= PORTS |=> !det_ptp;
    endproperty
    a_noport: assert property (p_noport) else $error("dead port");
    property p_rdidle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rdidle: assert property (p_rdidle) else $error("rdata");
    property p_rsvd;
        reg_rd && reg_addr == PARSE_CFG_OFS |=> reg_rdata[31:15] == '0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved set");
    property p_flag;
        det_ptp |-> det_valid;
    endproperty
    a_flag: assert property (p_flag) else $error("hit alone");
endmodule
bind ptpcfg_detect ptpcfg_detect_assertions #(.PORTS(PORTS)) u_chk (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frm_valid(frm_valid), .frm_port(frm_port),
    .frm_kind(frm_kind), .det_valid(det_valid), .det_ptp(det_ptp),
    .det_port(det_port));
`default_nettype wire

//--- ptpcfg_txpath.sv
// Purpose: transmit path model handing descriptors to the detector
// Assumes: one descriptor per call
// Notes:   idle destination fields are inverted so stale values never match
`default_nettype none
module ptpcfg_txpath
(
    // clock
    input  wire logic        mclk,
    // frame descriptor
    output var logic         frm_valid,
    output var logic [1:0]   frm_port,
    output var logic [3:0]   frm_kind,
    output var logic [47:0]  frm_dst_mac,
    output var logic [127:0] frm_dst_ip
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        frm_valid   = 1'b0;
        frm_port    = 2'h0;
        frm_kind    = 4'h1;
        frm_dst_mac = '0;
        frm_dst_ip  = '0;
    end
    task automatic send(input logic [1:0] p, input logic [3:0] k,
                        input logic [47:0] m, input logic [127:0] a);
        @(posedge mclk);
        frm_valid   <= 1'b1;
        frm_port    <= p;
        frm_kind    <= k;
        frm_dst_mac <= m;
        frm_dst_ip  <= a;
        @(posedge mclk);
        frm_valid   <= 1'b0;
        frm_dst_mac <= ~m;
        frm_dst_ip  <= ~a;
    endtask
endmodule
`default_nettype wire

//--- ptpcfg_detect_tb.sv
// Purpose: self-checking bench for transmit detection config
// Assumes: three ports, software MAC held as a level
// Notes:   waits are fixed by the one-cycle answer of both ports
`default_nettype none
module ptpcfg_detect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ptpcfg_pkg::*;
    logic         mclk = 1'b0;
    logic         rst = 1'b1;
    logic [9:0]   reg_addr = '0;
    logic [31:0]  reg_wdata = '0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [31:0]  reg_rdata;
    logic [47:0]  cmac = 48'h0a0b_0c0d_0e0f;
    logic         frm_valid, det_valid, det_ptp;
    logic [1:0]   frm_port, det_port;
    logic [3:0]   frm_kind;
    logic [47:0]  frm_dst_mac;
    logic [127:0] frm_dst_ip;
    int           n_errors = 0;
    int           tests_run = 0;
    always #5 mclk = ~mclk;
    ptpcfg_detect #(.PORTS(3)) dut (.mclk(mclk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .custom_mac_upper(cmac[47:32]), .custom_mac_lower(cmac[31:0]),
        .frm_valid(frm_valid), .frm_port(frm_port), .frm_kind(frm_kind),
        .frm_dst_mac(frm_dst_mac), .frm_dst_ip(frm_dst_ip),
        .det_valid(det_valid), .det_ptp(det_ptp), .det_port(det_port));
    ptpcfg_txpath u_tx (.mclk(mclk), .frm_valid(frm_valid),
        .frm_port(frm_port), .frm_kind(frm_kind),
        .frm_dst_mac(frm_dst_mac), .frm_dst_ip(frm_dst_ip));
    task automatic chk(input string w, input logic [31:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk_det(input logic e, input logic [1:0] p);
        tests_run++;
        if ({det_valid, det_ptp, det_port} !== {1'b1, e, p})
        begin
            n_errors++;
            $display("mismatch det expected %b seen %b", {1'b1, e, p},
                     {det_valid, det_ptp, det_port});
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk("reg_rdata", e, reg_rdata);
    endtask
    // timestamping stays off, so rewriting config is allowed
    task automatic cfg(input logic [1:0] p, input logic [31:0] v);
        wr(BANK_PORT_OFS, {22'h0, p, 5'h0, PARSE_CFG_BANK});
        wr(PARSE_CFG_OFS, v);
    endtask
    task automatic frm(input logic [1:0] p, input logic [3:0] k,
                       input logic [47:0] m, input logic [127:0] a,
                       input logic e);
        u_tx.send(p, k, m, a);
        #1;
        chk_det(e, p);
    endtask
    task automatic t_regs();
        rd(DET_STATUS_OFS, 32'h0);
        for (int p = 0; p < 3; p++)
        begin
            wr(BANK_PORT_OFS, {22'h0, 2'(p), 8'h02});
            rd(PARSE_CFG_OFS, 32'h0000_711f);
        end
        cfg(0, 32'hffff_ffff);
        rd(PARSE_CFG_OFS, 32'h0000_7fff);
        rd(10'h3fc, 32'h0);
        wr(BANK_PORT_OFS, 32'h0302);
        rd(PARSE_CFG_OFS, 32'h0);
        wr(BANK_PORT_OFS, 32'h0001);
        rd(PARSE_CFG_OFS, 32'h0);
        wr(PARSE_CFG_OFS, 32'h0);
        cfg(1, 32'h0);
        frm(1, PTPCFG_L2, 48'h0180_c200_000e, '0, 0);
        wr(BANK_PORT_OFS, 32'h0002);
        rd(PARSE_CFG_OFS, 32'h0000_7fff);
        cfg(0, 32'h711f);
    endtask
    task automatic t_l2();
        frm(0, PTPCFG_L2, 48'h0180_c200_000e, '0, 1);
        frm(0, PTPCFG_L2, 48'h011b_1900_0000, '0, 1);
        frm(0, PTPCFG_L2, 48'h011b_1900_0001, '0, 0);
        frm(0, PTPCFG_OTHER, 48'h0180_c200_000e, '0, 0);
        frm(3, PTPCFG_L2, 48'h0180_c200_000e, '0, 0);
        cfg(0, 32'h311f);
        frm(0, PTPCFG_L2, 48'h0180_c200_000e, '0, 0);
        cfg(0, 32'h511f);
        frm(0, PTPCFG_L2, 48'h011b_1900_0000, '0, 0);
    endtask
    task automatic t_sets();
        logic [15:0] lo, nx;
        for (int i = 0; i < 5; i++)
        begin
            lo = (i < 4) ? 16'h0181 + 16'(i) : 16'h006b;
            nx = (i < 3) ? lo + 16'h1 : (i == 3 ? 16'h006b : 16'h0181);
            cfg(0, 32'h1f | (32'h1 << (12 - i)));
            frm(0, PTPCFG_V4, {32'h0100_5e00, lo}, {112'h0e000, lo}, 1);
            frm(0, PTPCFG_V6, {32'h3333_0000, lo},
                {(i < 4 ? 16'hff05 : 16'hff02), 96'h0, lo}, 1);
            frm(0, PTPCFG_V4, {32'h0100_5e00, nx}, {112'h0e000, nx}, 0);
        end
    endtask
    task automatic t_checks();
        cfg(0, 32'h0007);
        frm(0, PTPCFG_L2, 48'h0a00_0000_0001, '0, 1);
        frm(0, PTPCFG_V4, 48'h0a00_0000_0001, 128'h1, 1);
        cfg(0, 32'h100f);
        frm(0, PTPCFG_V4, 48'h0100_5e00_0181, 128'h1, 1);
        frm(0, PTPCFG_V4, 48'h0a00_0000_0001, 128'he000_0181, 0);
        cfg(0, 32'h1017);
        frm(0, PTPCFG_V4, 48'h0a00_0000_0001, 128'he000_0181, 1);
        frm(0, PTPCFG_V4, 48'h0100_5e00_0181, 128'h1, 0);
        cfg(0, 32'h711e);
        frm(0, PTPCFG_V4, 48'h0100_5e00_0181, 128'he000_0181, 0);
        cfg(0, 32'h711d);
        frm(0, PTPCFG_V6, 48'h3333_0000_0181, 128'hff02 << 112 | 128'h181,
            0);
        cfg(0, 32'h711b);
        frm(0, PTPCFG_L2, 48'h0180_c200_000e, '0, 0);
    endtask
    task automatic t_custom();
        cfg(0, 32'h109f);
        frm(0, PTPCFG_L2, cmac, '0, 1);
        cfg(0, 32'h105f);
        frm(0, PTPCFG_V6, cmac, 128'hff05 << 112 | 128'h181, 1);
        cfg(0, 32'h103f);
        frm(0, PTPCFG_V4, cmac, 128'he000_0181, 1);
        rd(DET_STATUS_OFS, 32'h8004_0013);
        cfg(0, 32'h101f);
        frm(0, PTPCFG_V4, cmac, 128'he000_0181, 0);
        rd(DET_STATUS_OFS, 32'h0004_0013);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #500_000;
        n_errors++;
        give_verdict();
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_l2();
        t_sets();
        t_checks();
        t_custom();
        give_verdict();
    end
endmodule
`default_nettype wire
